//--- design/pmsi_defs.svh
// Offsets, widths, encodings, reset values and timing counts of the sleep/idle block
`ifndef PMSI_DEFS_SVH
`define PMSI_DEFS_SVH

// Register indices on the plain register port
`define PMSI_ADDR_W 4
`define PMSI_DATA_W 8
`define PMSI_REG_CTRL 4'h0
`define PMSI_REG_CFG 4'h1
`define PMSI_REG_STATUS 4'h2

// Reset values
`define PMSI_CTRL_RST 7'h00
`define PMSI_CFG_RST 6'h00
`define PMSI_RD_IDLE 8'h00

// Clock select encodings
`define PMSI_SEL_SEC 2'h1
`define PMSI_FREQ_OFF 3'h0

// Timing: clock period and analogue intervals in ns
`define PMSI_CLK_PERIOD_NS 10
`define PMSI_CPU_START_DELAY_NS 2000
`define PMSI_INT_OSC_STABILIZE_NS 1000
`define PMSI_WDOG_PERIOD_NS 4000000

// Least times round up to whole cycles
`define PMSI_CSD_CYCLES \
  ((`PMSI_CPU_START_DELAY_NS + `PMSI_CLK_PERIOD_NS - 1) / `PMSI_CLK_PERIOD_NS)
`define PMSI_IOB_CYCLES \
  ((`PMSI_INT_OSC_STABILIZE_NS + `PMSI_CLK_PERIOD_NS - 1) / `PMSI_CLK_PERIOD_NS)
`define PMSI_WDOG_CYCLES (`PMSI_WDOG_PERIOD_NS / `PMSI_CLK_PERIOD_NS)

// Counter widths and zero values
`define PMSI_DLY_W 16
`define PMSI_WDOG_W 20
`define PMSI_DLY_ZERO 16'h0000
`define PMSI_WDOG_ZERO 20'h0_0000

`endif

//--- design/pmsi_pkg.sv
// Types shared by the sleep/idle control block
`include "pmsi_defs.svh"

package pmsi_pkg;

  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_IDLE, ST_WAKE, ST_RST}
    pmsi_state_t;

  typedef enum logic [1:0] {SRC_NONE, SRC_PRI, SRC_SEC, SRC_INT} pmsi_src_t;

  typedef struct packed {
    logic low_src_sel;
    logic [2:0] freq_sel;
    logic [1:0] clk_sel;
    logic idle_en;
  } pmsi_ctrl_t;

  typedef struct packed {
    logic pri_internal;
    logic glb_irq_en;
    logic two_speed_en;
    logic fscm_en;
    logic wdog_en;
    logic sec_osc_en;
  } pmsi_cfg_t;

  typedef struct packed {
    logic [`PMSI_ADDR_W-1:0] addr;
    logic [`PMSI_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pmsi_bus_req_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic pri_osc_en;
    logic sec_osc_en;
    logic fast_int_en;
    logic slow_int_en;
  } pmsi_clk_ctl_t;

endpackage

//--- design/pmsi_ctrl.sv
// Sleep and idle mode control with watchdog and start-up delays
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pmsi_defs.svh"

// Overview of operation
// - Sleep with idle clear stops oscillator, clears all clock status flags.
// - Sleep wake waits for selected source, or runs on internal block.
// - Sleep with idle set gates CPU clock; status flags follow the selected idle source.
// - Idle exits only by interrupt, watchdog or reset; start delay only after the first two.
// - Wake-up never alters idle enable or clock select bits.
// - Watchdog time-out in sleep or idle wakes into selected run mode.
// - Primary idle keeps primary clock; primary ready flag stays set.
// - Secondary idle: primary off, ready flag clear, secondary flag set.
// - Secondary idle refused if oscillator disabled; clocks wait for it.
// - Secondary idle wake: CPU resumes on secondary after start delay.
// - Internal idle: primary off, ready clear, lower select bit ignored.
// - Fast internal output enabled by frequency or low source select.
// - Already stable fast output keeps flag; all zero keeps it clear.
// - Internal idle wake resumes on internal; slow source kept as needed.
// - Enabled interrupt flag starts wake-up from sleep or idle.
// - Interrupt wake branches to vector only with global enable set.
// - Interrupt and watchdog exits apply the start delay; execution begins once the source is also ready.
// - Watchdog time-out while executing causes watchdog reset.
// - Watchdog cleared by sleep, clear, clock loss, frequency write.
// - Reset exit held until primary ready; internal flag if internal.
// - Two-speed or monitor: run on internal until primary ready; if primary is ready at reset exit, run stays on internal, primary off.
// - Status flags tell which source clocks the device.
// - Start delay runs concurrently with other start-up delays.
module pmsi_ctrl
  import pmsi_pkg::*;
#(
  parameter int unsigned CSD_CYCLES = `PMSI_CSD_CYCLES,
  parameter int unsigned IOB_CYCLES = `PMSI_IOB_CYCLES,
  parameter int unsigned WDOG_CYCLES = `PMSI_WDOG_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire pmsi_bus_req_t BUS_REQ,
  output logic [`PMSI_DATA_W-1:0] RD_DATA,
  input wire logic SLEEP_EXEC,
  input wire logic WDOG_CLEAR_EXEC,
  input wire logic [7:0] IRQ_FLAGS,
  input wire logic [7:0] IRQ_ENABLES,
  input wire logic RESET_REQ,
  input wire logic PRI_OSC_READY,
  input wire logic SEC_OSC_RUNNING,
  input wire logic CLOCK_LOSS,
  output pmsi_clk_ctl_t CLK_CTL,
  output logic RESET_HOLD,
  output logic CPU_RESUME,
  output logic VECTOR_BRANCH,
  output logic WDOG_RESET
);

  pmsi_state_t state_q;
  pmsi_src_t src_q;
  pmsi_ctrl_t ctrl_q;
  pmsi_cfg_t cfg_q;
  logic two_spd_q;
  logic wake_irq_q;
  logic pri_ready_q;
  logic int_stable_q;
  logic sec_active_q;
  logic [`PMSI_DLY_W-1:0] csd_cnt_q;
  logic [`PMSI_DLY_W-1:0] iob_cnt_q;
  logic [`PMSI_WDOG_W-1:0] wdog_cnt_q;

  logic int_wake;
  logic wdog_to;
  logic wdog_clr;
  logic dev_rst;
  logic pm_state;
  logic wake_go;
  logic sleep_go;
  logic sec_block;
  logic csd_done;
  logic src_rdy;
  logic fast_en;
  logic pri_fallback;
  logic wr_ctrl;
  logic wr_cfg;
  logic freq_wr_int;
  logic resume;

  function automatic pmsi_src_t run_src(input logic [1:0] sel);
    // Upper bit alone picks the internal block; lower bit is then ignored
    if (sel[1])
      return SRC_INT;
    else if (sel == `PMSI_SEL_SEC)
      return SRC_SEC;
    else
      return SRC_PRI;
  endfunction

  function automatic logic src_ok(input pmsi_src_t s);
    unique case (s)
      SRC_PRI: return PRI_OSC_READY;
      SRC_SEC: return SEC_OSC_RUNNING;
      SRC_INT: return 1'b1;
      SRC_NONE: return 1'b0;
    endcase
  endfunction

  assign int_wake = |(IRQ_FLAGS & IRQ_ENABLES);
  assign pm_state = (state_q == ST_SLEEP) || (state_q == ST_IDLE);
  assign wdog_to = cfg_q.wdog_en && !wdog_clr &&
    (wdog_cnt_q == `PMSI_WDOG_W'(WDOG_CYCLES - 1));
  assign dev_rst = RESET_REQ || (wdog_to && state_q == ST_RUN);
  assign wake_go = pm_state && (int_wake || wdog_to) && !RESET_REQ;
  assign sleep_go = (state_q == ST_RUN) && SLEEP_EXEC && !dev_rst;
  assign sec_block = ctrl_q.idle_en && !cfg_q.sec_osc_en &&
    (run_src(ctrl_q.clk_sel) == SRC_SEC);
  assign csd_done = (csd_cnt_q == `PMSI_DLY_ZERO);
  assign src_rdy = src_ok(src_q);
  assign pri_fallback = (cfg_q.two_speed_en || cfg_q.fscm_en) &&
    !PRI_OSC_READY;
  assign fast_en = ((src_q == SRC_INT) &&
    ((ctrl_q.freq_sel != `PMSI_FREQ_OFF) || ctrl_q.low_src_sel)) ||
    ((src_q == SRC_PRI) && cfg_q.pri_internal);
  assign resume = (state_q == ST_WAKE) && csd_done && src_rdy;
  assign wr_ctrl = BUS_REQ.wr && (BUS_REQ.addr == `PMSI_REG_CTRL);
  assign wr_cfg = BUS_REQ.wr && (BUS_REQ.addr == `PMSI_REG_CFG);
  assign freq_wr_int = wr_ctrl && (src_q == SRC_INT) &&
    (BUS_REQ.wdata[5:3] != ctrl_q.freq_sel);
  assign wdog_clr = SLEEP_EXEC || WDOG_CLEAR_EXEC ||
    (CLOCK_LOSS && cfg_q.fscm_en) || freq_wr_int;

  // Mode sequencing and the source that clocks the device
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || dev_rst)
    begin
      state_q <= ST_RST;
      src_q <= SRC_PRI;
      two_spd_q <= 1'b0;
      wake_irq_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_RUN:
        begin
          if (sleep_go && !sec_block)
          begin
            // Entering a managed mode first shuts the waiting primary down
            two_spd_q <= 1'b0;
            if (ctrl_q.idle_en)
            begin
              state_q <= ST_IDLE;
              src_q <= run_src(ctrl_q.clk_sel);
            end
            else
            begin
              state_q <= ST_SLEEP;
              src_q <= SRC_NONE;
            end
          end
          else if (two_spd_q && PRI_OSC_READY)
          begin
            src_q <= SRC_PRI;
            two_spd_q <= 1'b0;
          end
        end
        ST_SLEEP:
        begin
          if (wake_go)
          begin
            state_q <= ST_WAKE;
            wake_irq_q <= int_wake;
            if ((run_src(ctrl_q.clk_sel) == SRC_PRI) && pri_fallback)
            begin
              src_q <= SRC_INT;
              two_spd_q <= 1'b1;
            end
            else
              src_q <= run_src(ctrl_q.clk_sel);
          end
        end
        ST_IDLE:
        begin
          // Source stays that of the idle mode, so run mode matches it
          if (wake_go)
          begin
            state_q <= ST_WAKE;
            wake_irq_q <= int_wake;
          end
        end
        ST_WAKE:
        begin
          if (resume)
            state_q <= ST_RUN;
        end
        ST_RST:
        begin
          if ((cfg_q.two_speed_en || cfg_q.fscm_en) && !cfg_q.pri_internal)
          begin
            state_q <= ST_RUN;
            src_q <= SRC_INT;
            two_spd_q <= !PRI_OSC_READY;
          end
          else if (cfg_q.pri_internal ? int_stable_q : PRI_OSC_READY)
            state_q <= ST_RUN;
        end
      endcase
    end
  end

  // CPU start delay, loaded on the wake event
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
      csd_cnt_q <= `PMSI_DLY_ZERO;
    else if (wake_go)
      csd_cnt_q <= `PMSI_DLY_W'(CSD_CYCLES);
    else if (!csd_done)
      csd_cnt_q <= csd_cnt_q - 1'b1;
  end

  // Fast internal output stabilisation; clocks keep running meanwhile
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || !fast_en)
    begin
      iob_cnt_q <= `PMSI_DLY_W'(IOB_CYCLES);
      int_stable_q <= 1'b0;
    end
    else if (iob_cnt_q != `PMSI_DLY_ZERO)
      iob_cnt_q <= iob_cnt_q - 1'b1;
    else
      int_stable_q <= 1'b1;
  end

  // Status flags follow the active source one cycle later
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      pri_ready_q <= 1'b0;
      sec_active_q <= 1'b0;
    end
    else
    begin
      pri_ready_q <= (src_q == SRC_PRI) && !cfg_q.pri_internal &&
        PRI_OSC_READY;
      sec_active_q <= (src_q == SRC_SEC);
    end
  end

  // Watchdog counter; wraps on time-out
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || !cfg_q.wdog_en || wdog_clr || wdog_to)
      wdog_cnt_q <= `PMSI_WDOG_ZERO;
    else
      wdog_cnt_q <= wdog_cnt_q + 1'b1;
  end

  // Control bits change only by software or reset
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || dev_rst)
      ctrl_q <= `PMSI_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= BUS_REQ.wdata[6:0];
  end

  // Configuration survives device resets; only power-up clears it
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
      cfg_q <= `PMSI_CFG_RST;
    else if (wr_cfg)
      cfg_q <= BUS_REQ.wdata[5:0];
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST || !BUS_REQ.rd)
      RD_DATA <= `PMSI_RD_IDLE;
    else
    begin
      unique case (BUS_REQ.addr)
        `PMSI_REG_CTRL: RD_DATA <= {1'b0, ctrl_q};
        `PMSI_REG_CFG: RD_DATA <= {2'b00, cfg_q};
        `PMSI_REG_STATUS: RD_DATA <= {2'b00, state_q, sec_active_q,
          int_stable_q, pri_ready_q};
        default: RD_DATA <= `PMSI_RD_IDLE;
      endcase
    end
  end

  // Clock gating and oscillator enables
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
      CLK_CTL <= '0;
    else
    begin
      CLK_CTL.cpu_clk_en <= (state_q == ST_RUN) && src_rdy;
      CLK_CTL.periph_clk_en <= src_rdy && (state_q != ST_SLEEP) &&
        (state_q != ST_RST);
      CLK_CTL.pri_osc_en <= (src_q == SRC_PRI) || two_spd_q;
      CLK_CTL.sec_osc_en <= cfg_q.sec_osc_en;
      CLK_CTL.fast_int_en <= fast_en;
      CLK_CTL.slow_int_en <= cfg_q.wdog_en || (src_q == SRC_INT) ||
        (cfg_q.fscm_en && state_q != ST_SLEEP);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      RESET_HOLD <= 1'b1;
      CPU_RESUME <= 1'b0;
      VECTOR_BRANCH <= 1'b0;
      WDOG_RESET <= 1'b0;
    end
    else
    begin
      RESET_HOLD <= (state_q == ST_RST) || dev_rst;
      CPU_RESUME <= resume && !dev_rst;
      VECTOR_BRANCH <= resume && !dev_rst && wake_irq_q &&
        cfg_q.glb_irq_en;
      WDOG_RESET <= wdog_to && (state_q == ST_RUN);
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  sequence s_sleep_entry;
    sleep_go && !ctrl_q.idle_en;
  endsequence

  sequence s_secondary_idle_mode_entry;
    sleep_go && ctrl_q.idle_en && (ctrl_q.clk_sel == `PMSI_SEL_SEC) &&
      cfg_q.sec_osc_en;
  endsequence

  sequence s_resume;
    (state_q == ST_WAKE) ##1 (state_q == ST_RUN);
  endsequence

  a_sleep_flags_clear: assert property (
    s_sleep_entry |=> ##1 (!pri_ready_q && !int_stable_q && !sec_active_q))
    else $error("status flags not cleared on sleep entry");

  a_idle_cpu_off: assert property (
    (state_q == ST_IDLE) |=> !CLK_CTL.cpu_clk_en)
    else $error("cpu clocked during idle");

  a_ctrl_kept: assert property (
    (!wr_ctrl && !dev_rst) |=> $stable(ctrl_q))
    else $error("control bits changed without a write");

  a_wdog_wakes: assert property (
    (pm_state && wdog_to && !RESET_REQ) |=> (state_q == ST_WAKE))
    else $error("watchdog did not wake the device");

  a_secondary_idle_mode_flags: assert property (
    s_secondary_idle_mode_entry |=> ##1 (sec_active_q && !pri_ready_q))
    else $error("secondary idle flags wrong");

  a_sec_refused: assert property (
    (sleep_go && sec_block) |=> (state_q == ST_RUN))
    else $error("secondary idle entered with oscillator off");

  a_int_wakes: assert property (
    ((state_q == ST_IDLE) && int_wake && !RESET_REQ) |=>
      (state_q == ST_WAKE))
    else $error("enabled interrupt did not wake");

  a_branch_gie: assert property (
    VECTOR_BRANCH |-> (CPU_RESUME && $past(cfg_q.glb_irq_en)))
    else $error("vector branch without global enable");

  a_resume_delay: assert property (
    s_resume |-> ($past(csd_done) && CPU_RESUME))
    else $error("cpu resumed before start delay");

  a_wdog_run_reset: assert property (
    ((state_q == ST_RUN) && wdog_to) |=> (WDOG_RESET && RESET_HOLD))
    else $error("watchdog in run did not reset");

  a_wdog_cleared: assert property (
    (SLEEP_EXEC || WDOG_CLEAR_EXEC) |=> (wdog_cnt_q == `PMSI_WDOG_ZERO))
    else $error("watchdog not cleared");

endmodule
`default_nettype wire

//--- tb/pmsi_core_model.sv
// Processor core model that issues sleep and watchdog-clear instructions
`timescale 1ns/100ps
`default_nettype none
module pmsi_core_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cpu_clk_en,
  input wire logic hold,
  input wire logic sleep_req,
  input wire logic clear_req,
  output logic sleep_exec,
  output logic wdog_clear_exec
);
  logic run;

  // Unclocked or held core executes nothing, so no instruction leaks out
  assign run = cpu_clk_en && !hold && !rst;

  always_ff @(posedge clk)
  begin
    sleep_exec <= sleep_req && run;
    wdog_clear_exec <= clear_req && run;
  end
endmodule
`default_nettype wire

//--- tb/tb_power_managed_sleep_idle_control.sv
// Self-checking bench for the sleep and idle mode controller
`timescale 1ns/100ps
`default_nettype none
module tb_power_managed_sleep_idle_control
  import pmsi_pkg::*;
;
  localparam int CSD = 4;
  localparam int WDC = 64;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pmsi_bus_req_t bus = '0;
  logic [7:0] rd_data;
  logic [7:0] fl = 8'h00;
  logic [7:0] en = 8'h00;
  logic sleep_req = 1'b0;
  logic clr_req = 1'b0;
  logic rst_req = 1'b0;
  logic pri_rdy = 1'b0;
  logic secondary_run_mode = 1'b1;
  logic clk_loss = 1'b0;
  logic sleep_x;
  logic clr_x;
  logic hold;
  logic resume;
  logic vec;
  logic wdr;
  pmsi_clk_ctl_t ctl;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 54;
  int wd_n = 0;
  int n;
  logic [7:0] s;
  logic [2:0] f;
  logic v;

  always #5 clk = ~clk;

  pmsi_ctrl #(
    .CSD_CYCLES(CSD),
    .IOB_CYCLES(4),
    .WDOG_CYCLES(WDC)
  ) DUT (
    .CLOCK(clk),
    .SYS_RST(rst),
    .BUS_REQ(bus),
    .RD_DATA(rd_data),
    .SLEEP_EXEC(sleep_x),
    .WDOG_CLEAR_EXEC(clr_x),
    .IRQ_FLAGS(fl),
    .IRQ_ENABLES(en),
    .RESET_REQ(rst_req),
    .PRI_OSC_READY(pri_rdy),
    .SEC_OSC_RUNNING(secondary_run_mode),
    .CLOCK_LOSS(clk_loss),
    .CLK_CTL(ctl),
    .RESET_HOLD(hold),
    .CPU_RESUME(resume),
    .VECTOR_BRANCH(vec),
    .WDOG_RESET(wdr)
  );

  pmsi_core_model core (
    .clk(clk),
    .rst(rst),
    .cpu_clk_en(ctl.cpu_clk_en),
    .hold(hold),
    .sleep_req(sleep_req),
    .clear_req(clr_req),
    .sleep_exec(sleep_x),
    .wdog_clear_exec(clr_x)
  );

  always @(posedge clk)
  begin
    if (wdr === 1'b1)
      wd_n <= wd_n + 1;
  end

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({7'h00, got}, {7'h00, exp});
  endtask

  function automatic logic n_ok(input int lo);
    return n >= lo && n <= lo + 3;
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic st(input logic [3:0] a, input logic [7:0] e);
    rd(a, s);
    chk_reg(s, e);
  endtask

  task automatic go_sleep;
    @(posedge clk);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    cyc(3);
  endtask

  task automatic clr;
    @(posedge clk);
    clr_req <= 1'b1;
    @(posedge clk);
    clr_req <= 1'b0;
  endtask

  task automatic wait_run;
    int k;
    k = 0;
    cyc(2);
    while (hold !== 1'b0 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  // Wake by a random enabled interrupt, or by nothing but the watchdog
  task automatic wake(input logic irq, input int late);
    logic [7:0] b;
    b = irq ? 8'h01 << 3'($random(seed)) : 8'h00;
    @(posedge clk);
    fl <= 8'($random(seed)) & {8{irq}} | b;
    en <= 8'($random(seed)) & {8{irq}} | b;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
      if (n == late)
        pri_rdy <= 1'b1;
    end
    while (resume !== 1'b1 && n < 300);
    v = vec;
    fl <= 8'h00;
    en <= 8'h00;
  endtask

  initial
  begin
    #100000;
    n_mismatch++;
    complete_run;
  end

  initial
  begin
    cyc(16);
    rst <= 1'b0;
    cyc(5);
    #1;
    chk_bit(hold, 1'b1);
    st(4'h1, 8'h00);
    st(4'hF, 8'h00);
    wr(4'h2, 8'hFF);
    st(4'h2, 8'h20);
    pri_rdy <= 1'b1;
    wait_run;
    st(4'h2, 8'h01);
    wr(4'h1, 8'h01);
    go_sleep;
    st(4'h2, 8'h08);
    chk_reg({2'b00, ctl}, 8'h04);
    // Oscillator stopped; it comes back 10 cycles into the wake
    pri_rdy <= 1'b0;
    s = 8'($random(seed));
    fl <= s;
    en <= ~s;
    cyc(20);
    st(4'h2, 8'h08);
    wake(1'b1, 10);
    chk_bit(n_ok(10 + 1), 1'b1);
    chk_bit(v, 1'b0);
    st(4'h2, 8'h01);
    st(4'h0, 8'h00);
    wr(4'h1, 8'h10);
    wr(4'h0, 8'h01);
    go_sleep;
    st(4'h2, 8'h11);
    chk_reg({2'b00, ctl}, 8'h18);
    wake(1'b1, 0);
    chk_bit(n_ok(CSD + 2), 1'b1);
    chk_bit(v, 1'b1);
    st(4'h2, 8'h01);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h03);
    go_sleep;
    rd(4'h2, s);
    chk_reg(s & 8'h38, 8'h00);
    wr(4'h1, 8'h03);
    // Oscillator enabled but not yet running: peripheral clocks wait
    secondary_run_mode <= 1'b0;
    go_sleep;
    #1;
    chk_bit(ctl.periph_clk_en, 1'b0);
    @(posedge clk);
    secondary_run_mode <= 1'b1;
    st(4'h2, 8'h14);
    chk_reg({2'b00, ctl}, 8'h15);
    wake(1'b0, 0);
    chk_bit(n > 40 && n < WDC + CSD + 4, 1'b1);
    chk_bit(wd_n == 0 && !v, 1'b1);
    wr(4'h1, 8'h01);
    st(4'h2, 8'h04);
    st(4'h0, 8'h03);
    for (int i = 0; i < 2; i++)
    begin
      f = 3'(i * 5);
      wr(4'h0, {2'b00, f, 2'b11, 1'b1});
      go_sleep;
      cyc(4);
      st(4'h2, f != 0 ? 8'h12 : 8'h10);
      chk_bit(ctl.pri_osc_en, 1'b0);
      chk_bit(ctl.fast_int_en, f != 0);
      wake(1'b1, 0);
      chk_bit(n_ok(CSD + 2), 1'b1);
      st(4'h2, f != 0 ? 8'h02 : 8'h00);
    end
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h08);
    pri_rdy <= 1'b0;
    rst_req <= 1'b1;
    cyc(5);
    #1;
    chk_bit(hold, 1'b1);
    @(posedge clk);
    rst_req <= 1'b0;
    cyc(4);
    #1;
    chk_bit(hold, 1'b0);
    rd(4'h2, s);
    chk_reg(s & 8'h39, 8'h00);
    pri_rdy <= 1'b1;
    cyc(6);
    rd(4'h2, s);
    chk_reg(s & 8'h39, 8'h01);
    wr(4'h1, 8'h02);
    repeat (6)
    begin
      clr;
      cyc(30);
    end
    chk_bit(wd_n == 0, 1'b1);
    clr;
    n = 0;
    while (wd_n == 0 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk_bit(n > WDC - 4 && n < WDC + 6, 1'b1);
    wait_run;
    st(4'h0, 8'h00);
    // Clock loss with the monitor on keeps the watchdog from expiring
    wr(4'h1, 8'h06);
    repeat (3)
    begin
      @(posedge clk);
      clk_loss <= 1'b1;
      @(posedge clk);
      clk_loss <= 1'b0;
      cyc(40);
    end
    chk_bit(wd_n == 1, 1'b1);
    complete_run;
  end
endmodule
`default_nettype wire
